// ==== rtl/fsel_pkg.sv ====
// fault response selector: shared constants, register map and types
// assumes one 25 MHz clock and byte-wide register access
package fsel_pkg;

    // register offsets
    localparam logic [7:0] FSEL_GLOBAL_OFS  = 8'hb0;
    localparam logic [7:0] FSEL_FLY_AVG_OFS = 8'hb4;
    localparam logic [7:0] FSEL_OC2_PD_OFS  = 8'hb6;
    localparam logic [7:0] FSEL_PH_DIS_OFS  = 8'hbc;
    localparam logic [7:0] FSEL_CUR_ST_OFS  = 8'hd5;
    localparam logic [7:0] FSEL_SYS_ST_OFS  = 8'hd8;
    localparam logic [7:0] FSEL_CH_ST_OFS   = 8'hda;

    // field positions
    localparam int FSEL_GLOBAL_EN_BIT = 7;
    localparam int FSEL_FLY_SHORT_BIT = 7;
    localparam int FSEL_AVG_RESP_LSB  = 4;
    localparam int FSEL_OC2_RESP_LSB  = 6;
    localparam int FSEL_PD_EN_BIT     = 5;
    localparam int FSEL_ST_AVG_BIT    = 5;
    localparam int FSEL_ST_OC2_BIT    = 1;
    localparam int FSEL_ST_FLY_BIT    = 4;
    localparam int FSEL_PH_DIS_LSB    = 1;
    localparam int FSEL_NCH           = 6;

    // values after reset and write masks
    localparam logic [7:0] FSEL_GLOBAL_RST  = 8'h00;
    localparam logic [7:0] FSEL_FLY_AVG_RST = 8'h00;
    localparam logic [7:0] FSEL_OC2_PD_RST  = 8'h00;
    localparam logic [7:0] FSEL_PH_DIS_RST  = 8'h00;
    localparam logic [7:0] FSEL_OC2_PD_WMSK = 8'he0;
    localparam logic [7:0] FSEL_PH_DIS_WMSK = 8'h7e;

    // hiccup restart delay
    localparam int FSEL_CLK_HZ      = 25_000_000;
    localparam int FSEL_HICCUP_MS   = 500;
    localparam int FSEL_HICCUP_CYC  = FSEL_HICCUP_MS * (FSEL_CLK_HZ / 1000);
    localparam int FSEL_TMR_W       = 24;

    typedef enum logic [1:0]
    {
        FSEL_FLAG   = 2'b00,
        FSEL_HICCUP = 2'b01,
        FSEL_LATCH  = 2'b10,
        FSEL_FLAG2  = 2'b11
    } fsel_resp_t;

    typedef enum logic [1:0]
    {
        FSEL_RUN     = 2'b00,
        FSEL_HALT    = 2'b01,
        FSEL_COUNT   = 2'b10,
        FSEL_LATCHED = 2'b11
    } fsel_fsm_t;

    // pins entering from outside the clock domain
    typedef struct packed
    {
        logic                en;
        logic                pwm_en;
        logic                boost;
        logic                avg_out_oc;
        logic                avg_in_oc;
        logic                fly_short;
        logic [FSEL_NCH-1:0] oc2;
        logic [1:0]          mode;
    } fsel_pins_t;

    typedef struct packed
    {
        fsel_pins_t s1;
        fsel_pins_t s2;
        fsel_pins_t s3;
        fsel_pins_t q;
    } fsel_sync_t;

endpackage

// ==== rtl/fsel_sync.sv ====
// fault response selector: three-stage pin synchroniser
// assumes asynchronous pins; a change counts once stages two and three agree
`timescale 1ns/100ps
module fsel_sync
    import fsel_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire fsel_pins_t pins_raw,
    output fsel_pins_t      pins_q
);

    fsel_sync_t s_r;
    fsel_sync_t s_nxt;

    // shift chain; stage one feeds only stage two
    always_comb
    begin
        s_nxt    = s_r;
        s_nxt.s1 = pins_raw;
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
        s_nxt.q  = (~(s_r.s2 ^ s_r.s3) & s_r.s3) | ((s_r.s2 ^ s_r.s3) & s_r.q);
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign pins_q = s_r.q;

endmodule

// ==== rtl/fsel_top.sv ====
// fault response selector: picks flag, hiccup or latch-off per fault
// assumes byte register strobes on the same clock; pins are asynchronous
`timescale 1ns/100ps
module fsel_top
    import fsel_pkg::*;
#(
    parameter int HICCUP_CYC = FSEL_HICCUP_CYC
)
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire fsel_pins_t pins_raw,
    input  wire logic [2:0] phase_count,
    input  wire logic       alert_out_n_i,
    output logic            alert_out_n_o,
    output logic            alert_out_n_oe_n,
    input  wire logic       system_failure_out_n_i,
    output logic            system_failure_out_n_o,
    output logic            system_failure_out_n_oe_n,
    output logic            pwm_enable,
    output logic            flyback_enable
);

    localparam logic [FSEL_TMR_W-1:0] TMR_LAST = FSEL_TMR_W'(HICCUP_CYC - 1);

    typedef struct packed
    {
        logic                  gl_en;
        logic [7:0]            fly_avg;
        logic [7:0]            oc2_pd;
        logic [7:0]            ph_dis;
        logic                  st_avg;
        logic                  st_oc2;
        logic                  st_fly;
        logic [FSEL_NCH-1:0]   st_ch;
        fsel_fsm_t [1:0]       fsm;
        logic [1:0][FSEL_TMR_W-1:0] tmr;
        logic                  fly_latch;
        logic [7:0]            rdata;
        logic                  alert_oe_n;
        logic                  sysf_oe_n;
        logic                  pwm_ok;
        logic                  fly_ok;
    } fsel_state_t;

    fsel_state_t         s_r;
    fsel_state_t         s_nxt;
    fsel_pins_t          p;
    logic                avg_hit;
    logic                oc2_any;
    logic                pd_fault;
    logic                fly_flag_only;
    logic [1:0]          cond;
    fsel_resp_t          resp_a;
    fsel_resp_t          resp_o;
    fsel_resp_t [1:0]    resp;
    logic [FSEL_NCH-1:0] dis_cfg;
    logic [3:0]          ndis;
    logic [7:0]          clr;

    // pins reach the logic only through the synchroniser
    fsel_sync u_sync
    (
        .clock    (clock),
        .rst      (rst),
        .pins_raw (pins_raw),
        .pins_q   (p)
    );

    assign avg_hit = p.boost ? p.avg_in_oc : p.avg_out_oc;
    assign oc2_any = |p.oc2;

    assign resp_a = s_r.gl_en ? fsel_resp_t'(s_r.fly_avg[FSEL_AVG_RESP_LSB +: 2])
                              : fsel_resp_t'(p.mode);
    assign resp_o = s_r.gl_en ? fsel_resp_t'(s_r.oc2_pd[FSEL_OC2_RESP_LSB +: 2])
                              : fsel_resp_t'(p.mode);
    // flyback short source; the pin halts unless it asks for flagging
    assign fly_flag_only = s_r.gl_en ? s_r.fly_avg[FSEL_FLY_SHORT_BIT]
                                     : (p.mode == FSEL_FLAG || p.mode == FSEL_FLAG2);

    // only phases inside the configured count take part in the vote
    for (genvar i = 0; i < FSEL_NCH; i++)
    begin : g_ph
        assign dis_cfg[i] = s_r.ph_dis[FSEL_PH_DIS_LSB + i] && (3'(i) < phase_count);
    end

    always_comb
    begin
        ndis = 4'h0;
        for (int i = 0; i < FSEL_NCH; i++)
            ndis = ndis + {3'h0, dis_cfg[i]};
    end

    assign pd_fault = s_r.oc2_pd[FSEL_PD_EN_BIT] && ({ndis, 1'b0} > {2'h0, phase_count});

    assign cond = {oc2_any | pd_fault, avg_hit};
    assign resp = {resp_o, resp_a};

    // write-one-to-clear strobes for the status registers
    assign clr = reg_wr ? reg_wdata : 8'h00;

    always_comb
    begin
        s_nxt = s_r;

        // host writes to control registers
        if (reg_wr)
        begin
            case (reg_addr)
                FSEL_GLOBAL_OFS:  s_nxt.gl_en   = reg_wdata[FSEL_GLOBAL_EN_BIT];
                FSEL_FLY_AVG_OFS: s_nxt.fly_avg = reg_wdata;
                FSEL_OC2_PD_OFS:  s_nxt.oc2_pd  = reg_wdata & FSEL_OC2_PD_WMSK;
                FSEL_PH_DIS_OFS:  s_nxt.ph_dis  = reg_wdata & FSEL_PH_DIS_WMSK;
                default:          s_nxt.gl_en   = s_r.gl_en;
            endcase
        end

        s_nxt.st_avg = (s_r.st_avg & ~(reg_addr == FSEL_CUR_ST_OFS && clr[FSEL_ST_AVG_BIT])) | avg_hit;
        s_nxt.st_oc2 = (s_r.st_oc2 & ~(reg_addr == FSEL_CUR_ST_OFS && clr[FSEL_ST_OC2_BIT])) | oc2_any;
        s_nxt.st_ch  = (s_r.st_ch & ~((reg_addr == FSEL_CH_ST_OFS) ? clr[FSEL_NCH-1:0] : 6'h00)) | p.oc2;
        s_nxt.st_fly = (s_r.st_fly & ~(reg_addr == FSEL_SYS_ST_OFS && clr[FSEL_ST_FLY_BIT])) | p.fly_short;

        for (int k = 0; k < 2; k++)
        begin
            case (s_r.fsm[k])
                FSEL_RUN:
                begin
                    // flag codes 00 and 11 stay running
                    if (cond[k] && resp[k] == FSEL_HICCUP)
                        s_nxt.fsm[k] = FSEL_HALT;
                    else if (cond[k] && resp[k] == FSEL_LATCH)
                        s_nxt.fsm[k] = FSEL_LATCHED;
                end
                FSEL_HALT:
                begin
                    if (!cond[k])
                    begin
                        s_nxt.fsm[k] = FSEL_COUNT;
                        s_nxt.tmr[k] = '0;
                    end
                end
                FSEL_COUNT:
                begin
                    // restart after full delay
                    // a returning fault restarts the wait from zero
                    if (cond[k])
                        s_nxt.fsm[k] = FSEL_HALT;
                    else if (s_r.tmr[k] == TMR_LAST)
                        s_nxt.fsm[k] = FSEL_RUN;
                    else
                        s_nxt.tmr[k] = s_r.tmr[k] + 1'b1;
                end
                FSEL_LATCHED:
                begin
                    if (!p.pwm_en)
                        s_nxt.fsm[k] = FSEL_RUN;
                end
                default: s_nxt.fsm[k] = FSEL_RUN;
            endcase
        end

        if (p.fly_short && !fly_flag_only)
            s_nxt.fly_latch = 1'b1;

        // chip enable low clears every halt
        if (!p.en)
        begin
            s_nxt.fsm       = {FSEL_RUN, FSEL_RUN};
            s_nxt.fly_latch = 1'b0;
        end

        // registered read data, unmapped offsets read zero
        case (reg_addr)
            FSEL_GLOBAL_OFS:  s_nxt.rdata = {s_r.gl_en, 7'h00};
            FSEL_FLY_AVG_OFS: s_nxt.rdata = s_r.fly_avg;
            FSEL_OC2_PD_OFS:  s_nxt.rdata = s_r.oc2_pd;
            FSEL_PH_DIS_OFS:  s_nxt.rdata = s_r.ph_dis;
            FSEL_CUR_ST_OFS:  s_nxt.rdata = {2'h0, s_r.st_avg, 3'h0, s_r.st_oc2, 1'b0};
            FSEL_SYS_ST_OFS:  s_nxt.rdata = {3'h0, s_r.st_fly, 4'h0};
            FSEL_CH_ST_OFS:   s_nxt.rdata = {2'h0, s_r.st_ch};
            default:          s_nxt.rdata = 8'h00;
        endcase

        s_nxt.alert_oe_n = ~(s_nxt.st_avg | s_nxt.st_oc2 | s_nxt.st_fly);
        s_nxt.sysf_oe_n  = ~s_nxt.fly_latch;
        s_nxt.pwm_ok = p.en && p.pwm_en && !s_r.fly_latch
                       && s_r.fsm[0] == FSEL_RUN && s_r.fsm[1] == FSEL_RUN;
        s_nxt.fly_ok = p.en && !s_r.fly_latch;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s_r            <= '0;
            s_r.gl_en      <= FSEL_GLOBAL_RST[FSEL_GLOBAL_EN_BIT];
            s_r.fly_avg    <= FSEL_FLY_AVG_RST;
            s_r.oc2_pd     <= FSEL_OC2_PD_RST;
            s_r.ph_dis     <= FSEL_PH_DIS_RST;
            s_r.alert_oe_n <= 1'b1;
            s_r.sysf_oe_n  <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    // open-drain pins only ever pull low
    assign reg_rdata                 = s_r.rdata;
    assign alert_out_n_o             = 1'b0;
    assign alert_out_n_oe_n          = s_r.alert_oe_n;
    assign system_failure_out_n_o    = 1'b0;
    assign system_failure_out_n_oe_n = s_r.sysf_oe_n;
    assign pwm_enable                = s_r.pwm_ok;
    assign flyback_enable            = s_r.fly_ok;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence fly_stop_s;
        !s_r.sysf_oe_n ##1 !s_r.fly_ok;
    endsequence

    gl_mode_pick_a: assert property (
        !s_r.gl_en && p.mode == FSEL_LATCH && avg_hit && p.en && s_r.fsm[0] == FSEL_RUN
        |=> s_r.fsm[0] == FSEL_LATCHED) else $error("mode pin latch not taken");
    avg_boost_src_a: assert property (
        p.boost && p.avg_in_oc |=> s_r.st_avg) else $error("boost input overcurrent not flagged");
    avg_flag_run_a: assert property (
        avg_hit && resp_a == FSEL_FLAG && s_r.fsm[0] == FSEL_RUN
        |=> s_r.fsm[0] == FSEL_RUN ##1 !s_r.alert_oe_n) else $error("flag-only changed switching");
    avg_halt_gate_a: assert property (
        s_r.fsm[0] != FSEL_RUN |=> !s_r.pwm_ok) else $error("pwm enabled while halted");
    hiccup_time_a: assert property (
        s_r.fsm[1] == FSEL_RUN && $past(s_r.fsm[1]) == FSEL_COUNT && $past(p.en)
        |-> $past(s_r.tmr[1]) == TMR_LAST) else $error("hiccup restart not at full delay");
    latch_hold_a: assert property (
        s_r.fsm[0] == FSEL_LATCHED && p.pwm_en && p.en |=> s_r.fsm[0] == FSEL_LATCHED)
        else $error("latch released without toggle");
    avg_code11_a: assert property (
        avg_hit && resp_a == FSEL_FLAG2 && s_r.fsm[0] == FSEL_RUN |=> s_r.fsm[0] == FSEL_RUN)
        else $error("code 11 halted switching");
    fly_sysfail_a: assert property (
        p.fly_short && !fly_flag_only && p.en |=> fly_stop_s) else $error("short did not stop system");
    fly_flag_a: assert property (
        p.fly_short && fly_flag_only && !s_r.fly_latch |=> s_r.sysf_oe_n && s_r.st_fly)
        else $error("flag-only short pulled system fail");
    oc2_chan_a: assert property (
        p.oc2[0] |=> s_r.st_ch[0] && s_r.st_oc2 && !s_r.alert_oe_n) else $error("channel trip not recorded");
    oc2_flag_a: assert property (
        oc2_any && !pd_fault && resp_o == FSEL_FLAG && s_r.fsm[1] == FSEL_RUN
        |=> s_r.fsm[1] == FSEL_RUN) else $error("level-two flag-only halted");
    pd_hiccup_a: assert property (
        pd_fault && p.en && resp_o == FSEL_HICCUP && s_r.fsm[1] == FSEL_RUN
        |=> s_r.fsm[1] == FSEL_HALT) else $error("phase-disable fault ignored");
    reserved_zero_a: assert property (
        reg_wr && reg_addr == FSEL_OC2_PD_OFS |=> s_r.oc2_pd[4:0] == 5'h00)
        else $error("reserved bits stored");
    pd_off_a: assert property (
        !s_r.oc2_pd[FSEL_PD_EN_BIT] && !oc2_any && s_r.fsm[1] == FSEL_RUN |=> s_r.fsm[1] == FSEL_RUN)
        else $error("phase disable faulted while off");
    sticky_avg_a: assert property (
        s_r.st_avg && !(reg_wr && reg_addr == FSEL_CUR_ST_OFS && reg_wdata[FSEL_ST_AVG_BIT])
        |=> s_r.st_avg) else $error("status bit lost");

endmodule

// ==== tb/fault_response_selector_bench.sv ====
// fault response selector bench: reset, then a table of fault cases, reserved bits and phase tests
// assumes the design hiccup count shortened to 20 cycles; open-drain pins pulled up
`timescale 1ns/100ps
module fault_response_selector_bench
    import fsel_pkg::*;
;
    typedef struct packed
    {
        logic [7:0] b0, b4, b6;
        logic [1:0] mode;
        logic [9:0] flt;
        logic       pw, pa, sf;
        logic [7:0] sa, sv;
    } fsel_row_t;

    logic       clock, rst, reg_wr, pwm_enable, fly_en;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [2:0] ph_cnt;
    logic       al_o, al_oe_n, sf_o, sf_oe_n;
    fsel_pins_t pins;
    int         failures, tests_run, cycles;
    // flt is boost, avg out, avg in, flyback short, level-two channels 5..0
    fsel_row_t  rows [17] = '{
        '{8'h80, 8'h00, 8'h00, 2'h0, 10'h100, 1'h1, 1'h1, 1'h1, 8'hd5, 8'h20},
        '{8'h80, 8'h10, 8'h00, 2'h0, 10'h100, 1'h0, 1'h1, 1'h1, 8'hd5, 8'h20},
        '{8'h80, 8'h20, 8'h00, 2'h0, 10'h100, 1'h0, 1'h0, 1'h1, 8'hd5, 8'h20},
        '{8'h80, 8'h30, 8'h00, 2'h0, 10'h100, 1'h1, 1'h1, 1'h1, 8'hd5, 8'h20},
        '{8'h00, 8'h20, 8'h00, 2'h0, 10'h100, 1'h1, 1'h1, 1'h1, 8'hd5, 8'h20},
        '{8'h00, 8'h00, 8'h00, 2'h2, 10'h100, 1'h0, 1'h0, 1'h1, 8'hd5, 8'h20},
        '{8'h80, 8'h00, 8'h00, 2'h0, 10'h280, 1'h1, 1'h1, 1'h1, 8'hd5, 8'h20},
        '{8'h80, 8'h10, 8'h00, 2'h0, 10'h300, 1'h1, 1'h1, 1'h1, 8'hd5, 8'h00},
        '{8'h80, 8'h00, 8'h00, 2'h0, 10'h040, 1'h0, 1'h0, 1'h0, 8'hd8, 8'h10},
        '{8'h80, 8'h80, 8'h00, 2'h0, 10'h040, 1'h1, 1'h1, 1'h1, 8'hd8, 8'h10},
        '{8'h00, 8'h80, 8'h00, 2'h1, 10'h040, 1'h0, 1'h0, 1'h0, 8'hd8, 8'h10},
        '{8'h80, 8'h00, 8'h00, 2'h0, 10'h008, 1'h1, 1'h1, 1'h1, 8'hda, 8'h08},
        '{8'h80, 8'h00, 8'h40, 2'h0, 10'h001, 1'h0, 1'h1, 1'h1, 8'hd5, 8'h02},
        '{8'h80, 8'h00, 8'h80, 2'h0, 10'h020, 1'h0, 1'h0, 1'h1, 8'hda, 8'h20},
        '{8'h80, 8'h00, 8'hc0, 2'h0, 10'h008, 1'h1, 1'h1, 1'h1, 8'hd5, 8'h02},
        '{8'h00, 8'h00, 8'h80, 2'h0, 10'h008, 1'h1, 1'h1, 1'h1, 8'hd5, 8'h02},
        '{8'h00, 8'h00, 8'h00, 2'h1, 10'h001, 1'h0, 1'h1, 1'h1, 8'hda, 8'h01}
    };

    // pulled-up open-drain wires, as the far side sees them
    wire alert_n = al_oe_n ? 1'b1 : al_o;
    wire sf_n    = sf_oe_n ? 1'b1 : sf_o;

    fsel_top #(.HICCUP_CYC(20)) i_dut
    (
        .clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .pins_raw(pins), .phase_count(ph_cnt),
        .alert_out_n_i(alert_n), .alert_out_n_o(al_o), .alert_out_n_oe_n(al_oe_n),
        .system_failure_out_n_i(sf_n), .system_failure_out_n_o(sf_o),
        .system_failure_out_n_oe_n(sf_oe_n), .pwm_enable(pwm_enable), .flyback_enable(fly_en)
    );

    fsel_host i_host
    (
        .clock(clock), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
    );

    // clock and the hang guard
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 8000)
        begin
            failures++;
            complete_run;
        end
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        i_host.rd(a, v);
        chk_byte(v, exp);
    endtask

    // bounded wait for switching to come back
    task automatic wait_pwm;
        for (int k = 0; k < 40 && pwm_enable !== 1'b1; k++)
            cyc(1);
        chk_bit(pwm_enable, 1'b1);
    endtask

    // one fault case: raise, remove, then restart and clear as the controller would
    task automatic run_row(input fsel_row_t r);
        i_host.wr(FSEL_GLOBAL_OFS, r.b0);
        i_host.wr(FSEL_FLY_AVG_OFS, r.b4);
        i_host.wr(FSEL_OC2_PD_OFS, r.b6);
        pins.mode = r.mode;
        {pins.boost, pins.avg_out_oc, pins.avg_in_oc, pins.fly_short, pins.oc2} = r.flt;
        cyc(12);
        chk_bit(pwm_enable, r.pw);
        chk_bit(sf_n, r.sf);
        chk_bit(alert_n, r.sv == 8'h00);
        rd_chk(r.sa, r.sv);
        {pins.boost, pins.avg_out_oc, pins.avg_in_oc, pins.fly_short, pins.oc2} = '0;
        cyc(8);
        chk_bit(pwm_enable, r.pw);
        rd_chk(r.sa, r.sv);
        cyc(40);
        chk_bit(pwm_enable, r.pa);
        pins.en = 1'b0;
        cyc(6);
        pins.en = 1'b1;
        i_host.wr(FSEL_CUR_ST_OFS, 8'hff);
        i_host.wr(FSEL_SYS_ST_OFS, 8'hff);
        i_host.wr(FSEL_CH_ST_OFS, 8'hff);
        rd_chk(r.sa, 8'h00);
        wait_pwm;
        chk_bit(alert_n, 1'b1);
        $display("test row done at %0t", $time);
    endtask

    // reset, the table, then reserved bits and the phase-disable fault
    initial
    begin
        rst = 1'b1;
        pins = '0;
        ph_cnt = 3'h4;
        cycles = 0;
        failures = 0;
        tests_run = 0;
        cyc(10);
        rst = 1'b0;
        chk_bit(pwm_enable, 1'b0);
        rd_chk(FSEL_FLY_AVG_OFS, 8'h00);
        rd_chk(FSEL_OC2_PD_OFS, 8'h00);
        chk_bit(alert_n, 1'b1);
        chk_bit(sf_n, 1'b1);
        pins.en = 1'b1;
        pins.pwm_en = 1'b1;
        wait_pwm;
        $display("test reset done");
        foreach (rows[i])
            run_row(rows[i]);
        i_host.wr(FSEL_OC2_PD_OFS, 8'hff);
        rd_chk(FSEL_OC2_PD_OFS, 8'he0);
        i_host.wr(8'h42, 8'hff);
        rd_chk(8'h42, 8'h00);
        $display("test reserved done");
        // four phases configured; half is allowed, three off is not
        i_host.wr(FSEL_GLOBAL_OFS, 8'h80);
        i_host.wr(FSEL_OC2_PD_OFS, 8'h80);
        i_host.wr(FSEL_PH_DIS_OFS, 8'h0e);
        cyc(6);
        chk_bit(pwm_enable, 1'b1);
        i_host.wr(FSEL_PH_DIS_OFS, 8'h06);
        i_host.wr(FSEL_OC2_PD_OFS, 8'ha0);
        cyc(6);
        chk_bit(pwm_enable, 1'b1);
        i_host.wr(FSEL_PH_DIS_OFS, 8'h0e);
        cyc(6);
        chk_bit(pwm_enable, 1'b0);
        i_host.wr(FSEL_PH_DIS_OFS, 8'h00);
        cyc(30);
        chk_bit(pwm_enable, 1'b0);
        pins.pwm_en = 1'b0;
        cyc(6);
        pins.pwm_en = 1'b1;
        wait_pwm;
        // six phases: three off is only half; two phases: two off is a fault
        ph_cnt = 3'h6;
        i_host.wr(FSEL_PH_DIS_OFS, 8'h0e);
        cyc(6);
        chk_bit(pwm_enable, 1'b1);
        ph_cnt = 3'h2;
        cyc(6);
        chk_bit(pwm_enable, 1'b0);
        $display("test phase disable done");
        complete_run;
    end
endmodule

// ==== tb/fsel_host.sv ====
// fault response selector bench: system controller model on the register port
// assumes byte writes by one-cycle strobe and read data one cycle after the address
`timescale 1ns/100ps
module fsel_host
(
    input  wire logic       clock,
    output logic            reg_wr,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    // idle bus at time zero
    initial
    begin
        reg_wr    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end

    // one write per strobe, changed just after the edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(posedge clock);
        #1;
        reg_wr    = 1'b0;
        reg_wdata = ~d;  // stale data never lingers on the bus
    endtask

    // address is held over one edge, then the registered byte is taken
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        #1;
        reg_addr = a;
        @(posedge clock);
        #1;
        d = reg_rdata;
    endtask
endmodule
